// *** tdmp_pkg.sv ***
/*
 * Package for the serial-port framing and status-flag block: register map,
 * frame geometry, rate select encodings and reset values.
 * Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package tdmp_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int BCLK_HZ = 11_000_000;
    // Bit clock enable: divide the system clock, rounded down
    localparam int BCLK_DIV = CLK_HZ / BCLK_HZ;
    localparam int SLOTS = 12;
    localparam int SLOT_BITS = 16;
    localparam int FRAME_BITS = SLOTS * SLOT_BITS;
    localparam int CLR_BIT = 15;
    localparam int PD_BIT = 15;
    localparam int RST_BIT = 14;
    localparam int RW_BIT = 6;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0] ADDR_RATE0 = 8'h10;

    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
    localparam logic [15:0] PERIOD_RESET = 16'h00C0;

    typedef enum logic [2:0] {
        TDMP_RATE_MAX = 3'h0,
        TDMP_RATE_MODEM = 3'h1,
        TDMP_RATE_CAPT = 3'h2,
        TDMP_RATE_PLAY = 3'h3,
        TDMP_RATE_SYNTH = 3'h4,
        TDMP_RATE_SER1 = 3'h5,
        TDMP_RATE_SER0 = 3'h6
    } tdmp_rate_t;

    typedef enum logic [1:0] {
        TDMP_RUN = 2'h0,
        TDMP_PD_LAST = 2'h1,
        TDMP_PD_OFF = 2'h2
    } tdmp_pwr_t;
endpackage

// *** tdmp_port.sv ***
/*
 * Framing and status-flag logic of the serial audio port: bit clock enable,
 * frame sync, slot counting, reset and power-down status flags, and an
 * AXI4-Lite register file with a sticky interrupt.
 * Assumes chip_reset_n, the reset command and the power-down request come
 * from other clock domains; the partner shifts slot data on the bit clock.
 */
// Function
// [RULE1] Reset pin or reset command sets reset flag
// [RULE2] Status-clear bit clears reset flag
// [RULE3] Reset flag blocks indirect register writes
// [RULE4] Write accepted in frame that clears flag
// [RULE5] Reset command holds flag one full frame
// [RULE6] Reset pin or power-down sets power-down flag
// [RULE7] One flagged frame sent before port stops; the code sends two whole flagged frames before it stops
// [RULE8] Power-down flag clears only after wake
// [RULE9] One-bit frame sync before first bit
// [RULE10] Twelve slots of sixteen bits
// [RULE11] Default frame is 192 bit clocks
// [RULE12] Frame rate selectable among seven rates
// [RULE13] Valid and request flags mark meaningful slots
// [RULE14] Partner may ignore flags at equal rates
// [RULE15] Monitor or intercept any converter stream
// [RULE16] Clear bit 15 in, flags bits 15,14 out
// [RULE17] Slower rates add idle bit clocks
// [RULE18] Rate chosen by three-bit select field
// [RULE19] Partner reissues writes dropped while flagged
`timescale 1ns/100ps
module tdmp_port #(
    parameter int PERIOD_W = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic chip_reset_n,
    input wire logic pnp_reset_cmd,
    input wire logic powerdown_req,
    input wire logic ctrl_word_valid,
    input wire logic [15:0] ctrl_word,
    input wire logic [15:0] stream_flags,
    input wire logic [4:0] intercept_en,
    output logic bclk_en,
    output logic frame_sync_out,
    output logic port_active,
    output logic [3:0] slot_index,
    output logic [3:0] bit_index,
    output logic [15:0] status_word,
    output logic ind_write_en,
    output logic [4:0] intercept_sel,
    output logic irq
);
    localparam int DIV_W = $clog2(tdmp_pkg::BCLK_DIV);

    // Synchronisers for asynchronous inputs
    logic [1:0] rpin_s, rcmd_s, pdr_s;
    logic rcmd_prev;
    always_ff @(posedge aclk) begin
        rpin_s <= {rpin_s[0], chip_reset_n};
        rcmd_s <= {rcmd_s[0], pnp_reset_cmd};
        pdr_s <= {pdr_s[0], powerdown_req};
        rcmd_prev <= rcmd_s[1];
    end
    logic pin_rst, cmd_evt, pd_req;
    assign pin_rst = !rpin_s[1];
    assign cmd_evt = rcmd_s[1] && !rcmd_prev;
    assign pd_req = pdr_s[1];

    // Registers
    logic [2:0] rate_sel_q, rate_sel_d;
    logic [2:0] irq_stat_q, irq_stat_d, irq_mask_q, irq_mask_d;
    logic [PERIOD_W-1:0] period_q [0:6];
    logic [PERIOD_W-1:0] period_d [0:6];

    // Frame timing
    logic [DIV_W-1:0] div_q, div_d;
    logic [PERIOD_W-1:0] bcnt_q, bcnt_d;
    logic fs_q, fs_d;
    logic rst_flag_q, rst_flag_d, pd_flag_q, pd_flag_d;
    logic [1:0] hold_q, hold_d;
    tdmp_pkg::tdmp_pwr_t pwr_q, pwr_d;
    logic frame_end;
    logic [PERIOD_W-1:0] period_cur;

    always_comb begin
        period_cur = period_q[(rate_sel_q > 3'h6) ? 3'h0 : rate_sel_q];
        if (rate_sel_q > 3'h6 || period_cur < PERIOD_W'(tdmp_pkg::FRAME_BITS)) begin
            period_cur = PERIOD_W'(tdmp_pkg::FRAME_BITS); // [RULE11]
        end
    end

    assign bclk_en = (div_q == '0) && (pwr_q != tdmp_pkg::TDMP_PD_OFF);
    // A shorter period chosen mid-frame ends the frame at once instead of wrapping the counter
    assign frame_end = bclk_en && (bcnt_q >= period_cur - PERIOD_W'(1));

    always_comb begin
        div_d = div_q;
        bcnt_d = bcnt_q;
        fs_d = fs_q;
        if (div_q == DIV_W'(tdmp_pkg::BCLK_DIV - 1)) begin
            div_d = '0;
        end else begin
            div_d = div_q + DIV_W'(1);
        end
        if (bclk_en) begin
            // Counts past 191 are idle bit clocks padding slower frames
            bcnt_d = frame_end ? '0 : bcnt_q + PERIOD_W'(1); // [RULE17]
            // Sync rides the last bit clock before bit 0
            fs_d = (bcnt_q == period_cur - PERIOD_W'(2)); // [RULE9]
        end
    end
    assign frame_sync_out = fs_q;
    assign port_active = pwr_q != tdmp_pkg::TDMP_PD_OFF;
    // Slot and bit position; idle bit clocks report slot 15
    always_comb begin
        if (bcnt_q < PERIOD_W'(tdmp_pkg::FRAME_BITS)) begin
            slot_index = 4'(bcnt_q / PERIOD_W'(tdmp_pkg::SLOT_BITS)); // [RULE10]
            bit_index = 4'(bcnt_q % PERIOD_W'(tdmp_pkg::SLOT_BITS));
        end else begin
            slot_index = 4'hF;
            bit_index = 4'h0;
        end
    end

    // Status flags; ctrl_word_valid pulses once per frame with slot 0 input
    logic clr;
    assign clr = ctrl_word_valid && ctrl_word[tdmp_pkg::CLR_BIT]; // [RULE16]
    always_comb begin
        rst_flag_d = rst_flag_q;
        pd_flag_d = pd_flag_q;
        hold_d = hold_q;
        pwr_d = pwr_q;
        if (frame_end && hold_q != 2'h0) begin
            hold_d = hold_q - 2'h1;
        end
        if (clr && hold_q == 2'h0) begin
            rst_flag_d = 1'b0; // [RULE2]
        end
        if (clr && !pd_req && pwr_q == tdmp_pkg::TDMP_RUN) begin
            pd_flag_d = 1'b0; // [RULE8]
        end
        case (pwr_q)
            tdmp_pkg::TDMP_RUN: begin
                if (pd_req) begin
                    pwr_d = tdmp_pkg::TDMP_PD_LAST;
                end
            end
            tdmp_pkg::TDMP_PD_LAST: begin
                // Run until two whole frames have carried the flag
                if (frame_end && hold_q == 2'h0) begin
                    pwr_d = tdmp_pkg::TDMP_PD_OFF; // [RULE7]
                end
            end
            tdmp_pkg::TDMP_PD_OFF: begin
                if (!pd_req) begin
                    pwr_d = tdmp_pkg::TDMP_RUN;
                end
            end
            default: pwr_d = tdmp_pkg::TDMP_RUN;
        endcase
        if (pd_req && pwr_q == tdmp_pkg::TDMP_RUN) begin
            pd_flag_d = 1'b1; // [RULE6]
            hold_d = 2'h2;
        end
        if (cmd_evt) begin
            rst_flag_d = 1'b1; // [RULE1]
            hold_d = 2'h2; // [RULE5]
        end
        if (pin_rst) begin
            rst_flag_d = 1'b1; // [RULE1]
            pd_flag_d = 1'b1; // [RULE6]
        end
    end

    always_comb begin
        status_word = stream_flags; // [RULE13]
        status_word[tdmp_pkg::PD_BIT] = pd_flag_q; // [RULE16]
        status_word[tdmp_pkg::RST_BIT] = rst_flag_q;
    end
    // Clear in the same frame unblocks the write
    assign ind_write_en = ctrl_word_valid && !ctrl_word[tdmp_pkg::RW_BIT] &&
        (!rst_flag_q || (clr && hold_q == 2'h0)); // [RULE3] [RULE4]
    // Registered so the select seen by the sample paths never glitches
    logic [4:0] isel_q, isel_d;
    always_comb begin
        isel_d = intercept_en; // [RULE15]
    end
    assign intercept_sel = isel_q;

    // AXI4-Lite slave
    logic aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
    logic [7:0] awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic do_wr;
    logic [2:0] evt;
    assign s_axi_awready = !aw_q && !b_q;
    assign s_axi_wready = !w_q && !b_q;
    assign s_axi_arready = !r_q;
    assign s_axi_bvalid = b_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = r_q;
    assign s_axi_rdata = rd_q;
    assign s_axi_rresp = rresp_q;
    assign do_wr = aw_q && w_q && !b_q;
    assign evt = {pd_req && pwr_q == tdmp_pkg::TDMP_RUN, cmd_evt, frame_end};

    function automatic logic is_rate(input logic [7:0] a);
        is_rate = a >= tdmp_pkg::ADDR_RATE0 && a <= tdmp_pkg::ADDR_RATE0 + 8'h18 && a[1:0] == 2'h0;
    endfunction

    function automatic logic [2:0] rate_idx(input logic [7:0] a);
        rate_idx = 3'((a - tdmp_pkg::ADDR_RATE0) >> 2);
    endfunction

    always_comb begin
        aw_d = aw_q;
        w_d = w_q;
        b_d = b_q;
        r_d = r_q;
        awa_d = awa_q;
        wd_d = wd_q;
        rd_d = rd_q;
        bresp_d = bresp_q;
        rresp_d = rresp_q;
        rate_sel_d = rate_sel_q;
        irq_mask_d = irq_mask_q;
        period_d = period_q;
        irq_stat_d = irq_stat_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_d = 1'b1;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_d = 1'b1;
            wd_d = s_axi_wdata;
        end
        if (do_wr) begin
            aw_d = 1'b0;
            w_d = 1'b0;
            b_d = 1'b1;
            bresp_d = 2'h0;
            if (awa_q == tdmp_pkg::ADDR_CTRL) begin
                rate_sel_d = wd_q[2:0]; // [RULE12]
            end else if (awa_q == tdmp_pkg::ADDR_IRQ_STAT) begin
                irq_stat_d = irq_stat_q & ~wd_q[2:0];
            end else if (awa_q == tdmp_pkg::ADDR_IRQ_MASK) begin
                irq_mask_d = wd_q[2:0];
            end else if (is_rate(awa_q)) begin
                period_d[rate_idx(awa_q)] = wd_q[PERIOD_W-1:0];
            end else if (awa_q != tdmp_pkg::ADDR_STAT) begin
                bresp_d = 2'h2;
            end
        end else if (b_q && s_axi_bready) begin
            b_d = 1'b0;
        end
        // Set beats clear on the same cycle
        irq_stat_d = irq_stat_d | evt;
        if (s_axi_arvalid && s_axi_arready) begin
            r_d = 1'b1;
            rresp_d = 2'h0;
            rd_d = 32'h0;
            if (s_axi_araddr == tdmp_pkg::ADDR_CTRL) begin
                rd_d[2:0] = rate_sel_q;
            end else if (s_axi_araddr == tdmp_pkg::ADDR_STAT) begin
                rd_d[4:0] = {port_active, pwr_q, pd_flag_q, rst_flag_q};
            end else if (s_axi_araddr == tdmp_pkg::ADDR_IRQ_STAT) begin
                rd_d[2:0] = irq_stat_q;
            end else if (s_axi_araddr == tdmp_pkg::ADDR_IRQ_MASK) begin
                rd_d[2:0] = irq_mask_q;
            end else if (is_rate(s_axi_araddr)) begin
                rd_d[PERIOD_W-1:0] = period_q[rate_idx(s_axi_araddr)];
            end else begin
                rresp_d = 2'h2;
            end
        end else if (r_q && s_axi_rready) begin
            r_d = 1'b0;
        end
    end
    assign irq = |(irq_stat_q & irq_mask_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_q <= '0;
            bcnt_q <= '0;
            fs_q <= 1'b0;
            rst_flag_q <= 1'b1;
            pd_flag_q <= 1'b1;
            hold_q <= 2'h0;
            pwr_q <= tdmp_pkg::TDMP_RUN;
            aw_q <= 1'b0;
            w_q <= 1'b0;
            b_q <= 1'b0;
            r_q <= 1'b0;
            awa_q <= 8'h00;
            wd_q <= 32'h0;
            rd_q <= 32'h0;
            bresp_q <= 2'h0;
            rresp_q <= 2'h0;
            rate_sel_q <= tdmp_pkg::CTRL_RESET;
            irq_stat_q <= 3'h0;
            irq_mask_q <= tdmp_pkg::IRQ_MASK_RESET;
            isel_q <= 5'h00;
            for (int i = 0; i < 7; i++) begin
                period_q[i] <= PERIOD_W'(tdmp_pkg::PERIOD_RESET);
            end
        end else begin
            div_q <= div_d;
            bcnt_q <= bcnt_d;
            fs_q <= fs_d;
            rst_flag_q <= rst_flag_d;
            pd_flag_q <= pd_flag_d;
            hold_q <= hold_d;
            pwr_q <= pwr_d;
            aw_q <= aw_d;
            w_q <= w_d;
            b_q <= b_d;
            r_q <= r_d;
            awa_q <= awa_d;
            wd_q <= wd_d;
            rd_q <= rd_d;
            bresp_q <= bresp_d;
            rresp_q <= rresp_d;
            rate_sel_q <= rate_sel_d;
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
            isel_q <= isel_d;
            period_q <= period_d;
        end
    end
endmodule

// *** tdmp_port_chk.sv ***
/* Port-level checker for tdmp_port: framing, bit clock and status flags.
   Assumes one aclk domain and async inputs held for several cycles. */
`timescale 1ns/100ps
module tdmp_port_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic chip_reset_n,
    input wire logic powerdown_req,
    input wire logic ctrl_word_valid,
    input wire logic [15:0] ctrl_word,
    input wire logic bclk_en,
    input wire logic frame_sync_out,
    input wire logic port_active,
    input wire logic [3:0] slot_index,
    input wire logic [3:0] bit_index,
    input wire logic [15:0] status_word,
    input wire logic ind_write_en
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic clr_seen;
    assign clr_seen = ctrl_word_valid && ctrl_word[15];
    fs_width_a: assert property ($rose(frame_sync_out) |-> ##1 frame_sync_out [*8] ##1 !frame_sync_out)
        else $error("frame sync width");
    bclk_gap_a: assert property (bclk_en |=> !bclk_en [*8])
        else $error("bit clock spacing");
    fs_slot_a: assert property ($fell(frame_sync_out) && port_active |-> slot_index == 4'h0 && bit_index == 4'h0)
        else $error("frame start position");
    pin_flag_a: assert property (!chip_reset_n |-> ##[1:4] status_word[15:14] == 2'b11)
        else $error("pin reset flags");
    blk_wr_a: assert property (ctrl_word_valid && !ctrl_word[15] && status_word[14] |-> !ind_write_en)
        else $error("write not blocked");
    wr_src_a: assert property (ind_write_en |-> ctrl_word_valid && !ctrl_word[6])
        else $error("write without request");
    // The flag may sit one register behind the control word, hence two depths
    rst_clr_a: assert property ($fell(status_word[14]) |-> $past(clr_seen) || $past(clr_seen, 2))
        else $error("reset flag cleared alone");
    // The request passes two synchroniser stages before the flag logic sees it
    pd_clr_a: assert property ($fell(status_word[15]) |-> !$past(powerdown_req, 3) && ($past(clr_seen) || $past(clr_seen, 2)))
        else $error("power flag cleared early");
    stop_a: assert property ($fell(port_active) |-> status_word[15] && !bclk_en)
        else $error("stopped without flag");
endmodule
bind tdmp_port tdmp_port_chk chk_u (.aclk(aclk), .aresetn(aresetn), .chip_reset_n(chip_reset_n),
    .powerdown_req(powerdown_req), .ctrl_word_valid(ctrl_word_valid), .ctrl_word(ctrl_word), .bclk_en(bclk_en),
    .frame_sync_out(frame_sync_out), .port_active(port_active), .slot_index(slot_index), .bit_index(bit_index),
    .status_word(status_word), .ind_write_en(ind_write_en));

// *** tdmp_dsp_model.sv ***
/* Behavioural serial partner: sends one slot-0 control word per frame.
   Assumes frame_sync_out falls as the frame's first bit begins. */
`timescale 1ns/100ps
module tdmp_dsp_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic frame_sync_out,
    input wire logic clr,
    input wire logic wen,
    output logic ctrl_word_valid,
    output logic [15:0] ctrl_word
);
    logic fs_q;
    logic start;
    assign start = fs_q && !frame_sync_out;
    always_ff @(posedge aclk) begin
        fs_q <= frame_sync_out;
        if (!aresetn) begin
            ctrl_word_valid <= 1'b0;
            ctrl_word <= 16'h5A5A;
        end else begin
            ctrl_word_valid <= start;
            // Inverted every cycle outside its slot, so the stale word alternates with its complement
            ctrl_word <= start ? {clr, 7'h00, 1'b1, !wen, 6'h21} : ~ctrl_word;
        end
    end
endmodule

// *** tdmp_tb.sv ***
/* Self-checking bench for tdmp_port over AXI4-Lite and the partner model.
   Assumes the partner answers every frame start; bready and rready stay high. */
`timescale 1ns/100ps
module testbench;
    logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0;
    logic chip_reset_n = 1'b1, pnp = 1'b0, pdr = 1'b0, clr = 1'b0, wen = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rd;
    logic [1:0] br, rr, bsp;
    logic awr, wr_, bv, arr, rv, cwv, fs, bce, act, iwe, irq;
    logic [15:0] cw, sw;
    logic [3:0] si, bi;
    logic [4:0] isel;
    int err_total = 0, total_checks = 0, wcnt = 0, n, t;
    always #5 aclk = ~aclk;
    always @(posedge aclk) if (iwe === 1'b1) wcnt++;
    tdmp_port dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
        .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(1'b1), .s_axi_rdata(rd), .s_axi_rresp(rr),
        .chip_reset_n(chip_reset_n), .pnp_reset_cmd(pnp), .powerdown_req(pdr), .ctrl_word_valid(cwv),
        .ctrl_word(cw), .stream_flags(16'hA5C3), .intercept_en(5'h15), .bclk_en(bce), .frame_sync_out(fs),
        .port_active(act), .slot_index(si), .bit_index(bi), .status_word(sw), .ind_write_en(iwe),
        .intercept_sel(isel), .irq(irq));
    tdmp_dsp_model dsp_u (.aclk(aclk), .aresetn(aresetn), .frame_sync_out(fs), .clr(clr), .wen(wen),
        .ctrl_word_valid(cwv), .ctrl_word(cw));
    task automatic chk(input string s, input int e, input logic [31:0] g);
        total_checks++;
        if (g !== 32'(e)) begin
            err_total++;
            $display("unexpected %s: expected %0h seen %0h", s, e, g);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge aclk);
    endtask
    // Returns at a falling frame sync; n is aclk cycles since entry
    task automatic frm();
        for (n = 0; fs !== 1'b1 && n < 4000; n++) @(posedge aclk);
        for (n = n; fs === 1'b1 && n < 8000; n++) @(posedge aclk);
        if (n >= 4000) chk("frame sync timeout", 0, 32'(n));
    endtask
    // Waits as long as the slave needs; only the watchdog ends a hung transfer
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        do begin
            @(posedge aclk);
            awv <= awv && !awr;
            wv <= wv && !wr_;
        end while ((awv && !awr) || (wv && !wr_));
        do @(posedge aclk); while (bv !== 1'b1);
        bsp = br;
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        ara <= a;
        arv <= 1'b1;
        do @(posedge aclk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge aclk); while (rv !== 1'b1);
        d = rd;
        r = rr;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #900000;
        err_total++;
        wrap_up();
    end
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        cyc(12);
        aresetn <= 1'b1;
        cyc(1);
        chk("flags", 3, 32'(sw[15:14]));
        axr(tdmp_pkg::ADDR_RATE0, d, r);
        chk("period", 192, d);
        axr(tdmp_pkg::ADDR_STAT, d, r);
        chk("status reg", 32'h13, d);
        axr(8'h40, d, r);
        chk("unmapped", 2, 32'(r));
        axw(8'h40, 32'h7);
        chk("unmapped write", 2, 32'(bsp));
        chk("intercept", 32'h15, 32'(isel));
        frm();
        frm();
        chk("frame", tdmp_pkg::FRAME_BITS * tdmp_pkg::BCLK_DIV, 32'(n));
        chk("flags low", 16'h25C3, 32'(sw[13:0]));
        $display("test framing done");
        wen <= 1'b1;
        frm();
        frm();
        chk("blocked", 0, 32'(wcnt));
        clr <= 1'b1;
        frm();
        cyc(3);
        chk("writes", 1, 32'(wcnt));
        chk("cleared", 0, 32'(sw[15:14]));
        wen <= 1'b0;
        pnp <= 1'b1;
        cyc(4);
        pnp <= 1'b0;
        cyc(4);
        chk("cmd flag", 1, 32'(sw[14]));
        chk("irq masked", 0, 32'(irq));
        axw(tdmp_pkg::ADDR_IRQ_MASK, 32'h2);
        cyc(2);
        chk("irq", 1, 32'(irq));
        axw(tdmp_pkg::ADDR_IRQ_STAT, 32'h7);
        cyc(2);
        chk("irq clear", 0, 32'(irq));
        frm();
        cyc(3);
        chk("cmd hold", 1, 32'(sw[14]));
        frm();
        frm();
        cyc(3);
        chk("cmd clear", 0, 32'(sw[14]));
        $display("test flags done");
        pdr <= 1'b1;
        cyc(8);
        chk("pd flag", 1, 32'(sw[15]));
        for (t = 0; act === 1'b1 && t < 6000; t++) @(posedge aclk);
        cyc(20);
        chk("stopped", 0, 32'({act, bce}));
        chk("pd kept", 1, 32'(sw[15]));
        pdr <= 1'b0;
        frm();
        frm();
        cyc(3);
        chk("pd clear", 0, 32'(sw[15]));
        clr <= 1'b0;
        chip_reset_n <= 1'b0;
        cyc(6);
        chk("pin flags", 3, 32'(sw[15:14]));
        chip_reset_n <= 1'b1;
        $display("test power done");
        for (int i = 0; i < 7; i++) begin
            axw(8'(tdmp_pkg::ADDR_RATE0 + 4 * i), 32'(192 + 4 * i));
            axw(tdmp_pkg::ADDR_CTRL, 32'(i));
            axr(tdmp_pkg::ADDR_CTRL, d, r);
            chk("rate select", i, d);
            frm();
            frm();
            frm();
            chk("rate frame", (192 + 4 * i) * tdmp_pkg::BCLK_DIV, 32'(n));
        end
        // Select code seven falls back to the maximum rate, also from a longer frame
        axw(tdmp_pkg::ADDR_CTRL, 32'h7);
        frm();
        frm();
        frm();
        chk("rate seven", tdmp_pkg::FRAME_BITS * tdmp_pkg::BCLK_DIV, 32'(n));
        $display("test rates done");
        wrap_up();
    end
endmodule
